// ===== sysm_map.vh
// Register map, field positions, reset cause codes, keys and timing counts of the status monitor.
// Assumes a 100 MHz core clock and a 32-bit word-wide register port.
`ifndef SYSM_MAP_VH
`define SYSM_MAP_VH

// Register index: offsets are word indices, byte address is four times the index
`define SYSM_IDX_STATUS      12'h0ca
`define SYSM_IDX_CHECKSUM    12'h109
`define SYSM_IDX_STATUS_CLR  12'h19d
`define SYSM_IDX_SOFT_RESET  12'h1bf
`define SYSM_IDX_CFG_BASE    12'h1c0
`define SYSM_IDX_IRQ_STATUS  12'h1e0
`define SYSM_IDX_IRQ_MASK    12'h1e1
`define SYSM_CFG_WORDS       5'd23

// Status fields
`define SYSM_BIT_POLARITY    11
`define SYSM_BIT_PHASE_LAT   9
`define SYSM_BIT_RAM_FAIL    8
`define SYSM_BIT_SUPPLY_LIVE 7
`define SYSM_BIT_SUPPLY_LAT  6
`define SYSM_CAUSE_HI        5
`define SYSM_CAUSE_LO        3
`define SYSM_BIT_CHK_FAIL    2
`define SYSM_BIT_PHASE_LIVE  1
`define SYSM_BIT_REF_LEAK    0

// Reset cause codes
`define SYSM_CAUSE_POWER     3'h0
`define SYSM_CAUSE_RX        3'h3
`define SYSM_CAUSE_SOFT      3'h4

// Keys and sums
`define SYSM_SOFT_RESET_KEY  32'h4572beaf
`define SYSM_CHECK_GOOD      32'hffffffff

// Interrupt status bits
`define SYSM_IRQ_PHASE       0
`define SYSM_IRQ_SUPPLY      1
`define SYSM_IRQ_CHECK       2
`define SYSM_IRQ_RAM         3
`define SYSM_IRQ_WIDTH       4

// Timing: figures in microseconds, counts in 100 MHz cycles
`define SYSM_CLK_MHZ         100
`define SYSM_SELFTEST_US     1250
`define SYSM_CHECK_US        5000
`define SYSM_SELFTEST_CYC    (`SYSM_SELFTEST_US * `SYSM_CLK_MHZ)
`define SYSM_CHECK_CYC       (`SYSM_CHECK_US * `SYSM_CLK_MHZ)

`endif

// ===== sysm_ram.v
// Small single-port memory used for the configuration words and the self-test.
// Assumes one clock; read data are registered.
`timescale 1ns/1ps
`default_nettype none

module sysm_ram #(
    parameter AW = 5,
    parameter DW = 32
) (
    input  wire          core_clk,   // Clock
    input  wire          wrEn,       // Write enable
    input  wire [AW-1:0] addr,       // Word address
    input  wire [DW-1:0] wrData,     // Write data
    output reg  [DW-1:0] rdData      // Registered read data
);
    reg [DW-1:0] mem [0:(1<<AW)-1];

    always @(posedge core_clk) begin
        if (wrEn) begin
            mem[addr] <= wrData;
        end
        rdData <= mem[addr];
    end
endmodule // sysm_ram

`default_nettype wire

// ===== sysm_status_monitor.v
// System status monitor: status word, clear, software reset, checksum and RAM self-test.
// Assumes analog indications arrive asynchronously; port signals are synchronous.
`timescale 1ns/1ps
`default_nettype none
`include "sysm_map.vh"

module sysm_status_monitor #(
    parameter SELFTEST_CYC = `SYSM_SELFTEST_CYC,
    parameter CHECK_CYC    = `SYSM_CHECK_CYC
) (
    input  wire        core_clk,      // 100 MHz clock
    input  wire        rst_b,         // Synchronous reset, active low
    input  wire        rxReset,       // Receive-line reset request pulse
    input  wire [11:0] regAddr,       // Register index
    input  wire [31:0] regWrData,     // Write data
    input  wire        regWr,         // Write strobe
    input  wire        regRd,         // Read strobe
    output reg  [31:0] regRdData,     // Read data, cycle after strobe
    input  wire        voltSignNeg,   // Voltage sign, 1 negative
    input  wire        phaseDone,     // Phase measurement finished
    input  wire        supplyLowAsync,// Supply comparator, asynchronous
    input  wire        refLeakAsync,  // Capacitor leak, asynchronous
    input  wire        ramFaultInj,   // Forces self-test data corruption
    output reg         softResetOut,  // One-cycle system reset pulse
    output reg         irq            // Level interrupt
);
    // ==========================================================
    // Synchronisers
    reg [1:0] supplySync_q;
    reg [1:0] leakSync_q;
    always @(posedge core_clk) begin
        supplySync_q <= {supplySync_q[0], supplyLowAsync};
        leakSync_q   <= {leakSync_q[0], refLeakAsync};
    end
    wire supplyLow = supplySync_q[1];
    wire refLeak   = leakSync_q[1];

    // ==========================================================
    // Global reset: pin, receive line or soft key
    reg        softReq_q;
    reg        rxReq_q;
    wire       globalRst = !rst_b || softReq_q || rxReq_q;
    reg  [2:0] resetCause_q;

    function decode;
        input [11:0] a;
        input [11:0] idx;
        begin
            decode = (a == idx);
        end
    endfunction

    wire wrSoft = regWr && decode(regAddr, `SYSM_IDX_SOFT_RESET);
    wire wrClr  = regWr && decode(regAddr, `SYSM_IDX_STATUS_CLR);
    wire wrCksm = regWr && decode(regAddr, `SYSM_IDX_CHECKSUM);
    wire wrMask = regWr && decode(regAddr, `SYSM_IDX_IRQ_MASK);
    wire wrCfg  = regWr && (regAddr >= `SYSM_IDX_CFG_BASE)
                  && (regAddr < `SYSM_IDX_CFG_BASE + {7'h0, `SYSM_CFG_WORDS});

    always @(posedge core_clk) begin
        if (!rst_b) begin
            softReq_q    <= 1'b0;
            rxReq_q      <= 1'b0;
            resetCause_q <= `SYSM_CAUSE_POWER;
            softResetOut <= 1'b0;
        end else begin
            softReq_q    <= wrSoft && (regWrData == `SYSM_SOFT_RESET_KEY);
            rxReq_q      <= rxReset;
            softResetOut <= wrSoft && (regWrData == `SYSM_SOFT_RESET_KEY);
            if (softReq_q) begin
                resetCause_q <= `SYSM_CAUSE_SOFT;
            end else if (rxReq_q) begin
                resetCause_q <= `SYSM_CAUSE_RX;
            end
        end
    end

    // ==========================================================
    // RAM self-test and configuration store
    localparam ST_WRITE = 4'b0001;
    localparam ST_READ  = 4'b0010;
    localparam ST_WAIT  = 4'b0100;
    localparam ST_DONE  = 4'b1000;
    reg  [3:0]  state_q;
    reg  [4:0]  ptr_q;
    reg         rdPend_q;
    reg  [4:0]  chkPtr_q;
    reg  [23:0] testCnt_q;
    reg         ramFail_q;
    wire [31:0] ramRd;

    function [31:0] pattern;
        input [4:0] a;
        begin
            pattern = {27'h5a5a5a5, a} ^ {a, 27'h2a5a5a5};
        end
    endfunction

    wire        testing = (state_q != ST_DONE);
    wire        cfgWrite = wrCfg || wrCksm;
    wire [4:0]  cfgIdx  = wrCksm ? `SYSM_CFG_WORDS : regAddr[4:0];
    reg  [4:0]  ramAddr;
    reg         ramWe;
    reg  [31:0] ramWd;
    always @* begin
        ramAddr = chkPtr_q;
        ramWe   = 1'b0;
        ramWd   = regWrData;
        if (testing) begin
            ramAddr = ptr_q;
            ramWe   = (state_q == ST_WRITE);
            ramWd   = pattern(ptr_q) ^ {31'h0, ramFaultInj};
        end else if (cfgWrite) begin
            ramAddr = cfgIdx;
            ramWe   = 1'b1;
        end
    end

    sysm_ram #(.AW(5), .DW(32)) uRam (
        .core_clk (core_clk),
        .wrEn     (ramWe),
        .addr     (ramAddr),
        .wrData   (ramWd),
        .rdData   (ramRd)
    );

    always @(posedge core_clk) begin
        if (globalRst) begin
            state_q   <= ST_WRITE;
            ptr_q     <= 5'd0;
            rdPend_q  <= 1'b0;
            testCnt_q <= 24'h0;
            ramFail_q <= 1'b0;
        end else begin
            rdPend_q <= (state_q == ST_READ);
            if (testing) begin
                testCnt_q <= testCnt_q + 24'h1;
            end
            case (state_q)
                ST_WRITE: begin
                    ptr_q <= ptr_q + 5'd1;
                    if (ptr_q == 5'd31) begin
                        state_q <= ST_READ;
                    end
                end
                ST_READ: begin
                    ptr_q <= ptr_q + 5'd1;
                    if (rdPend_q && ramRd != pattern(ptr_q - 5'd1)) begin
                        ramFail_q <= 1'b1;
                    end
                    if (ptr_q == 5'd31) begin
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (rdPend_q && ramRd != pattern(5'd31)) begin
                        ramFail_q <= 1'b1;
                    end
                    if (testCnt_q >= SELFTEST_CYC[23:0] - 24'd1) begin
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_q <= ST_DONE;
                end
                default: begin
                    state_q <= ST_WRITE;
                end
            endcase
        end
    end

    // ==========================================================
    // Periodic checksum over 23 config words plus checksum word
    reg  [31:0] sum_q;
    reg  [31:0] periodCnt_q;
    reg         summing_q;
    reg         sumPend_q;
    reg         chkFail_q;
    reg         chkDone_q;
    always @(posedge core_clk) begin
        if (globalRst) begin
            sum_q       <= 32'h0;
            periodCnt_q <= 32'h0;
            summing_q   <= 1'b0;
            sumPend_q   <= 1'b0;
            chkPtr_q    <= 5'd0;
            chkFail_q   <= 1'b0;
            chkDone_q   <= 1'b0;
        end else begin
            chkDone_q <= 1'b0;
            if (!testing) begin
                periodCnt_q <= (periodCnt_q >= CHECK_CYC - 1) ? 32'h0
                               : periodCnt_q + 32'h1;
            end
            if (!testing && periodCnt_q == 32'h0 && !summing_q) begin
                summing_q <= 1'b1;
                chkPtr_q  <= 5'd0;
                sum_q     <= 32'h0;
                sumPend_q <= 1'b0;
            end else if (summing_q && !cfgWrite) begin
                sumPend_q <= 1'b1;
                if (sumPend_q) begin
                    sum_q <= sum_q + ramRd;
                end
                if (chkPtr_q == `SYSM_CFG_WORDS + 5'd1) begin
                    summing_q <= 1'b0;
                    chkFail_q <= (sum_q + ramRd) != `SYSM_CHECK_GOOD;
                    chkDone_q <= 1'b1;
                end else begin
                    chkPtr_q <= chkPtr_q + 5'd1;
                end
            end else if (summing_q) begin
                sumPend_q <= 1'b0;
                chkPtr_q  <= chkPtr_q - {4'h0, sumPend_q};
            end
        end
    end

    // ==========================================================
    // Latched flags, clear register and interrupts
    reg        phaseLat_q;
    reg        supplyLat_q;
    reg        phasePrev_q;
    reg        supplyPrev_q;
    reg        ramFailPrev_q;
    reg  [3:0] irqStat_q;
    reg  [3:0] irqMask_q;
    wire       phaseRise  = phaseDone && !phasePrev_q;
    wire       supplyRise = supplyLow && !supplyPrev_q;
    wire       rdIrq      = regRd && decode(regAddr, `SYSM_IDX_IRQ_STATUS);
    wire [3:0] irqEvt     = {ramFail_q && !ramFailPrev_q, chkDone_q && chkFail_q,
                             supplyRise, phaseRise};
    always @(posedge core_clk) begin
        if (globalRst) begin
            phaseLat_q    <= 1'b0;
            supplyLat_q   <= 1'b0;
            phasePrev_q   <= 1'b0;
            supplyPrev_q  <= 1'b0;
            ramFailPrev_q <= 1'b0;
            irqStat_q     <= 4'h0;
            irqMask_q     <= 4'h0;
            irq           <= 1'b0;
        end else begin
            phasePrev_q   <= phaseDone;
            supplyPrev_q  <= supplyLow;
            ramFailPrev_q <= ramFail_q;
            if (phaseDone) begin
                phaseLat_q <= 1'b1;
            end else if (wrClr && regWrData[`SYSM_BIT_PHASE_LAT]) begin
                phaseLat_q <= 1'b0;
            end
            if (supplyLow) begin
                supplyLat_q <= 1'b1;
            end else if (wrClr && regWrData[`SYSM_BIT_SUPPLY_LAT]) begin
                supplyLat_q <= 1'b0;
            end
            irqStat_q <= (rdIrq ? 4'h0 : irqStat_q) | irqEvt;
            if (wrMask) begin
                irqMask_q <= regWrData[3:0];
            end
            irq <= |(((rdIrq ? 4'h0 : irqStat_q) | irqEvt)
                     & (wrMask ? regWrData[3:0] : irqMask_q));
        end
    end

    // ==========================================================
    // Status word and read port
    reg [31:0] status;
    always @* begin
        status = 32'h0;
        status[`SYSM_BIT_POLARITY]    = voltSignNeg;
        status[`SYSM_BIT_PHASE_LAT]   = phaseLat_q;
        status[`SYSM_BIT_RAM_FAIL]    = ramFail_q;
        status[`SYSM_BIT_SUPPLY_LIVE] = supplyLow;
        status[`SYSM_BIT_SUPPLY_LAT]  = supplyLat_q;
        status[`SYSM_CAUSE_HI:`SYSM_CAUSE_LO] = resetCause_q;
        status[`SYSM_BIT_CHK_FAIL]    = chkFail_q;
        status[`SYSM_BIT_PHASE_LIVE]  = phaseDone;
        status[`SYSM_BIT_REF_LEAK]    = refLeak;
    end

    always @(posedge core_clk) begin
        if (!rst_b) begin
            regRdData <= 32'h0;
        end else if (regRd) begin
            if (decode(regAddr, `SYSM_IDX_STATUS)) begin
                regRdData <= status;
            end else if (decode(regAddr, `SYSM_IDX_IRQ_STATUS)) begin
                regRdData <= {28'h0, irqStat_q};
            end else if (decode(regAddr, `SYSM_IDX_IRQ_MASK)) begin
                regRdData <= {28'h0, irqMask_q};
            end else begin
                regRdData <= 32'h0;
            end
        end else begin
            regRdData <= 32'h0;
        end
    end
endmodule // sysm_status_monitor

`default_nettype wire

// ===== sysm_status_monitor_checker.sv
// Port-level checks of the status monitor, bound to its top module.
// Assumes sysm_map.vh and a clean reset before traffic.
`timescale 1ns/1ps
`default_nettype none
`include "sysm_map.vh"

module sysm_status_monitor_checker #(
    parameter SELFTEST_CYC = 200,
    parameter CHECK_CYC    = 300
) (
    input wire logic        core_clk,       // Clock
    input wire logic        rst_b,          // Reset, active low
    input wire logic        rxReset,        // Receive-line reset
    input wire logic [11:0] regAddr,        // Register index
    input wire logic [31:0] regWrData,      // Write data
    input wire logic        regWr,          // Write strobe
    input wire logic        regRd,          // Read strobe
    input wire logic [31:0] regRdData,      // Read data
    input wire logic        voltSignNeg,    // Voltage sign
    input wire logic        phaseDone,      // Phase done
    input wire logic        supplyLowAsync, // Supply low
    input wire logic        refLeakAsync,   // Capacitor leak
    input wire logic        ramFaultInj,    // Fault injection
    input wire logic        softResetOut,   // Reset pulse
    input wire logic        irq             // Interrupt
);
    // ==================================================
    // Sequences
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    wire logic stRd = regRd && (regAddr == `SYSM_IDX_STATUS);
    sequence supplyHeld;
        $stable(supplyLowAsync)[*5];
    endsequence
    sequence leakHeld;
        $stable(refLeakAsync)[*5];
    endsequence
    sequence keyWrite;
        regWr && regAddr == `SYSM_IDX_SOFT_RESET && regWrData == `SYSM_SOFT_RESET_KEY;
    endsequence
    // ==================================================
    // Assertions
    AST_READ_IDLE: assert property (!regRd |=> regRdData == 32'h0)
        else $error("read data not zero outside read");
    AST_RSVD_ZERO: assert property (stRd |=> regRdData[31:12] == 20'h0 && !regRdData[10])
        else $error("reserved status bits set");
    AST_POLARITY: assert property (stRd |=> regRdData[11] == $past(voltSignNeg))
        else $error("polarity bit wrong");
    AST_PHASE_LIVE: assert property (stRd && $stable(phaseDone) |=> regRdData[1] == $past(phaseDone))
        else $error("live phase bit wrong");
    AST_PHASE_LATCH: assert property (stRd && phaseDone && $past(phaseDone) |=> regRdData[9])
        else $error("latched phase bit not set");
    AST_SUPPLY_LIVE: assert property (supplyHeld ##0 stRd |=> regRdData[7] == $past(supplyLowAsync))
        else $error("live supply bit wrong");
    AST_SUPPLY_LATCH: assert property (supplyHeld ##0 (stRd && supplyLowAsync) |=> regRdData[6])
        else $error("latched supply bit not set");
    AST_LEAK: assert property (leakHeld ##0 stRd |=> regRdData[0] == $past(refLeakAsync))
        else $error("leak bit wrong");
    AST_CAUSE_CODE: assert property (stRd |=> regRdData[5:3] != 3'h1 && regRdData[5:3] != 3'h2)
        else $error("reserved reset cause code");
    AST_SOFT_PULSE: assert property (keyWrite |=> softResetOut ##1 !softResetOut)
        else $error("soft reset pulse wrong");
    AST_NO_SPURIOUS: assert property (!(regWr && regWrData == `SYSM_SOFT_RESET_KEY) |=> !softResetOut)
        else $error("soft reset without key");
endmodule // sysm_status_monitor_checker

bind sysm_status_monitor sysm_status_monitor_checker #(
    .SELFTEST_CYC(SELFTEST_CYC), .CHECK_CYC(CHECK_CYC)
) sysm_status_monitor_checker_i (
    .core_clk(core_clk), .rst_b(rst_b), .rxReset(rxReset), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .voltSignNeg(voltSignNeg), .phaseDone(phaseDone), .supplyLowAsync(supplyLowAsync),
    .refLeakAsync(refLeakAsync), .ramFaultInj(ramFaultInj),
    .softResetOut(softResetOut), .irq(irq)
);
`default_nettype wire

// ===== tb_sysm_status_monitor.sv
// Self-checking bench of the status monitor.
// Assumes sysm_map.vh, the design and its checker compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "sysm_map.vh"

module tb_sysm_status_monitor;
    localparam int ST = 200;
    localparam int CK = 300;
    logic        core_clk, rst_b, rxReset, regWr, regRd, voltSignNeg;
    logic        phaseDone, supplyLowAsync, refLeakAsync, ramFaultInj;
    logic [11:0] regAddr;
    logic [31:0] regWrData;
    wire logic [31:0] regRdData;
    wire logic        softResetOut, irq;
    int          nErrors, comparisons, cycles;
    logic [31:0] d;

    sysm_status_monitor #(.SELFTEST_CYC(ST), .CHECK_CYC(CK)) sysm_status_monitor_i (
        .core_clk(core_clk), .rst_b(rst_b), .rxReset(rxReset), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .voltSignNeg(voltSignNeg), .phaseDone(phaseDone), .supplyLowAsync(supplyLowAsync),
        .refLeakAsync(refLeakAsync), .ramFaultInj(ramFaultInj),
        .softResetOut(softResetOut), .irq(irq)
    );

    always #5 core_clk = ~core_clk;

    // ==================================================
    // Bus and compare tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] msk);
        comparisons++;
        if ((got & msk) !== (exp & msk)) begin
            nErrors++;
            $display("mismatch at %0t: word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkFlag(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            nErrors++;
            $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge core_clk);
        regWr     <= 1'b1;
        regAddr   <= a;
        regWrData <= v;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        @(posedge core_clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        v = regRdData;
    endtask
    // Polls a status bit for a bounded number of cycles
    task automatic waitBit(input int b, input logic v, input int lim);
        logic [31:0] s;
        s = 32'h0;
        s[b] = ~v;
        for (int i = 0; i < lim && s[b] !== v; i += 2) rd(`SYSM_IDX_STATUS, s);
        chkFlag(s[b], v);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d errors %0d", comparisons, nErrors);
        if (nErrors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ==================================================
    // Scenarios
    task automatic tIdle;
        repeat (ST + 20) @(posedge core_clk);
        rd(`SYSM_IDX_STATUS, d);
        chk(d, 32'h0, 32'hffff_fffb);
        rd(12'h0ff, d);
        chk(d, 32'h0, 32'hffff_ffff);
    endtask
    task automatic tLive;
        @(posedge core_clk);
        {voltSignNeg, phaseDone, supplyLowAsync, refLeakAsync} <= 4'hf;
        repeat (6) @(posedge core_clk);
        wr(`SYSM_IDX_STATUS, 32'h0);
        rd(`SYSM_IDX_STATUS, d);
        chk(d, 32'h0000_0ac3, 32'h0000_0ac3);
        @(posedge core_clk);
        {voltSignNeg, phaseDone, supplyLowAsync, refLeakAsync} <= 4'h0;
        repeat (6) @(posedge core_clk);
        rd(`SYSM_IDX_STATUS, d);
        chk(d, 32'h0000_0240, 32'h0000_0ac3);
        wr(`SYSM_IDX_STATUS_CLR, 32'h0000_0240);
        rd(`SYSM_IDX_STATUS, d);
        chk(d, 32'h0, 32'h0000_0ac3);
    endtask
    task automatic tIrq;
        chkFlag(irq, 1'b0);
        wr(`SYSM_IDX_IRQ_MASK, 32'h3);
        repeat (2) @(posedge core_clk);
        #1;
        chkFlag(irq, 1'b1);
        rd(`SYSM_IDX_IRQ_STATUS, d);
        chk(d, 32'h3, 32'h3);
        repeat (2) @(posedge core_clk);
        #1;
        chkFlag(irq, 1'b0);
        wr(`SYSM_IDX_IRQ_MASK, 32'h0);
    endtask
    task automatic tChecksum;
        logic [31:0] s;
        s = 32'h0;
        for (int i = 0; i < 23; i++) begin
            wr(`SYSM_IDX_CFG_BASE + 12'(i), 32'(i + 1));
            s += 32'(i + 1);
        end
        wr(`SYSM_IDX_CHECKSUM, `SYSM_CHECK_GOOD - s);
        waitBit(2, 1'b0, CK + 40);
        wr(`SYSM_IDX_CHECKSUM, `SYSM_CHECK_GOOD - s + 32'h1);
        waitBit(2, 1'b1, CK + 40);
        rd(`SYSM_IDX_IRQ_STATUS, d);
        chk(d, 32'h4, 32'h4);
    endtask
    task automatic tResets;
        @(posedge core_clk);
        ramFaultInj <= 1'b1;
        rxReset     <= 1'b1;
        @(posedge core_clk);
        rxReset <= 1'b0;
        waitBit(8, 1'b1, ST + 40);
        rd(`SYSM_IDX_STATUS, d);
        chk(d, 32'h0000_0018, 32'h0000_0038);
        rd(`SYSM_IDX_IRQ_STATUS, d);
        chk(d, 32'h8, 32'h8);
        @(posedge core_clk);
        ramFaultInj <= 1'b0;
        wr(`SYSM_IDX_SOFT_RESET, `SYSM_SOFT_RESET_KEY);
        #1;
        chkFlag(softResetOut, 1'b1);
        repeat (ST + 20) @(posedge core_clk);
        rd(`SYSM_IDX_STATUS, d);
        chk(d, 32'h0000_0020, 32'h0000_0138);
        wr(`SYSM_IDX_SOFT_RESET, `SYSM_SOFT_RESET_KEY ^ 32'h1);
        #1;
        chkFlag(softResetOut, 1'b0);
    endtask

    // ==================================================
    // Main sequence and timeout
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            nErrors++;
            report_and_stop();
        end
    end
    initial begin
        core_clk = 1'b0;
        rst_b = 1'b0;
        {rxReset, regWr, regRd, voltSignNeg, phaseDone} = 5'h0;
        {supplyLowAsync, refLeakAsync, ramFaultInj} = 3'h0;
        regAddr = 12'h0;
        regWrData = 32'h0;
        nErrors = 0;
        comparisons = 0;
        cycles = 0;
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        tIdle();
        tLive();
        tIrq();
        tChecksum();
        tResets();
        report_and_stop();
    end
endmodule // tb_sysm_status_monitor
`default_nettype wire
